// [src/act_timer.sv]
// advanced control timer top: prescaler, counter, slave control and four channels
`timescale 1ns/10ps
`include "act_params.svh"
module act_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cnt_en_i,
  input act_pkg::act_cnt_mode_type cnt_mode_i,
  input act_pkg::act_slv_mode_type slv_mode_i,
  input wire logic opm_i,
  input wire logic [`ACT_CNT_W-1:0] psc_i,
  input wire logic [`ACT_CNT_W-1:0] arr_i,
  input wire logic [`ACT_REP_W-1:0] rep_i,
  input wire logic sw_update_i,
  input wire logic trg_i,
  input wire logic clr_en_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic [2:0] hall_i,
  input wire logic brk_i,
  input wire logic brk_en_i,
  input wire logic brk_rel_i,
  input wire logic dbg_halt_i,
  input wire logic dbg_freeze_i,
  input wire logic [`ACT_CNT_W-1:0] adc_pos_i,
  input act_pkg::act_ch_mode_type ch_mode_i [`ACT_NCH],
  input wire logic [`ACT_CNT_W-1:0] cmp_i [`ACT_NCH],
  input wire logic [`ACT_NCH-1:0] cap_i,
  input wire logic [`ACT_NCH-1:0] pol_i,
  input wire logic [`ACT_NCH-1:0] idle_lvl_i,
  input wire logic [`ACT_NCH-1:0] idle_n_lvl_i,
  input wire logic [`ACT_DT_W-1:0] dt_i,
  output logic [`ACT_NCH-1:0] ch_out_o,
  output logic [`ACT_NCH-1:0] ch_out_n_o,
  output logic [`ACT_CNT_W-1:0] cap_val_o [`ACT_NCH],
  output logic [`ACT_NCH-1:0] cc_evt_o,
  output logic [`ACT_CNT_W-1:0] cnt_o,
  output logic dir_dn_o,
  output logic upd_evt_o,
  output logic trg_evt_o,
  output logic brk_evt_o,
  output logic trgo_o,
  output logic adc_trg_o
);
  logic [`ACT_CNT_W-1:0] psc_cnt_q, psc_cnt_d, cnt_q, cnt_d, psc_q, psc_d, arr_q, arr_d;
  logic [`ACT_REP_W-1:0] rep_cnt_q, rep_cnt_d;
  logic dir_dn_q, dir_dn_d, run_q, run_d, en_q, trg_q, a_q, b_q;
  logic [2:0] hall_q;
  logic upd_q, upd_d, trg_evt_q, trg_evt_d, moved_q, moved_d, adc_q, adc_d;
  logic clr_q, clr_d, brk_act_q, brk_act_d, brk_q, brk_evt_q, brk_evt_d;
  logic trg_rise, hall_chg, enc_step, enc_up, freeze, gate_ok, src_ok, tick;
  logic reinit, per_end, at_top, at_zero;

  assign trg_rise = trg_i && !trg_q;
  assign hall_chg = (slv_mode_i == act_pkg::slv_hall) && (hall_i != hall_q);
  assign enc_step = (slv_mode_i == act_pkg::slv_encoder) && run_q && !freeze
                    && ((enc_a_i ^ a_q) || (enc_b_i ^ b_q));
  assign enc_up = enc_a_i ^ b_q;
  assign freeze = dbg_halt_i && dbg_freeze_i;
  assign gate_ok = (slv_mode_i != act_pkg::slv_gated) || trg_i;
  assign src_ok = (slv_mode_i != act_pkg::slv_extclk) || trg_rise;
  assign tick = run_q && gate_ok && src_ok && !freeze && (slv_mode_i != act_pkg::slv_encoder)
                && (psc_cnt_q == psc_q);
  assign reinit = sw_update_i || hall_chg || ((slv_mode_i == act_pkg::slv_reset) && trg_rise);
  assign at_top = cnt_q >= arr_q;
  assign at_zero = cnt_q == `ACT_CNT_ZERO;

  always_comb begin
    psc_cnt_d = psc_cnt_q;
    cnt_d = cnt_q;
    dir_dn_d = dir_dn_q;
    rep_cnt_d = rep_cnt_q;
    psc_d = psc_q;
    arr_d = arr_q;
    upd_d = 1'b0;
    per_end = 1'b0;
    run_d = run_q;
    if (run_q && gate_ok && src_ok && !freeze && (slv_mode_i != act_pkg::slv_encoder)) begin
      psc_cnt_d = tick ? `ACT_CNT_ZERO : psc_cnt_q + `ACT_CNT_STEP;
    end
    if (enc_step) begin
      if (enc_up) begin
        cnt_d = at_top ? `ACT_CNT_ZERO : cnt_q + `ACT_CNT_STEP;
        per_end = at_top;
      end else begin
        cnt_d = at_zero ? arr_q : cnt_q - `ACT_CNT_STEP;
        per_end = at_zero;
      end
      dir_dn_d = !enc_up;
    end else if (tick) begin
      case (cnt_mode_i)
        act_pkg::cm_down: begin
          cnt_d = at_zero ? arr_q : cnt_q - `ACT_CNT_STEP;
          per_end = at_zero;
          dir_dn_d = 1'b1;
        end
        act_pkg::cm_center: begin
          if (!dir_dn_q && at_top) begin
            dir_dn_d = 1'b1;
            cnt_d = cnt_q - `ACT_CNT_STEP;
            per_end = 1'b1;
          end else if (dir_dn_q && at_zero) begin
            dir_dn_d = 1'b0;
            cnt_d = cnt_q + `ACT_CNT_STEP;
            per_end = 1'b1;
          end else begin
            cnt_d = dir_dn_q ? cnt_q - `ACT_CNT_STEP : cnt_q + `ACT_CNT_STEP;
          end
        end
        default: begin
          cnt_d = at_top ? `ACT_CNT_ZERO : cnt_q + `ACT_CNT_STEP;
          per_end = at_top;
          dir_dn_d = 1'b0;
        end
      endcase
    end
    if (per_end) begin
      if (rep_cnt_q == `ACT_REP_ZERO) begin
        rep_cnt_d = rep_i;
        upd_d = 1'b1;
        if (opm_i) begin
          run_d = 1'b0;
        end
      end else begin
        rep_cnt_d = rep_cnt_q - `ACT_REP_STEP;
      end
    end
    if (reinit) begin
      cnt_d = (cnt_mode_i == act_pkg::cm_down) ? arr_i : `ACT_CNT_ZERO;
      dir_dn_d = cnt_mode_i == act_pkg::cm_down;
      psc_cnt_d = `ACT_CNT_ZERO;
      rep_cnt_d = rep_i;
      upd_d = 1'b1;
    end
    if (upd_d) begin
      psc_d = psc_i;
      arr_d = arr_i;
    end
    if ((cnt_en_i && !en_q && slv_mode_i != act_pkg::slv_trigger)
        || (slv_mode_i == act_pkg::slv_trigger && trg_rise)) begin
      run_d = 1'b1;
    end
    if (!cnt_en_i) begin
      run_d = 1'b0;
    end
  end

  always_comb begin
    moved_d = tick || enc_step || reinit;
    adc_d = moved_d && (cnt_d == adc_pos_i);
    trg_evt_d = hall_chg || (trg_rise && (slv_mode_i == act_pkg::slv_reset || slv_mode_i == act_pkg::slv_gated
                || slv_mode_i == act_pkg::slv_trigger || slv_mode_i == act_pkg::slv_extclk));
    // the limit holds until the period ends; a new trigger in that cycle still sets it
    clr_d = (clr_en_i && trg_i) || (clr_q && !per_end);
    brk_act_d = brk_en_i && (brk_i || (brk_act_q && !brk_rel_i));
    brk_evt_d = brk_en_i && brk_i && !brk_q;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      psc_cnt_q <= `ACT_CNT_ZERO;
      cnt_q <= `ACT_CNT_ZERO;
      psc_q <= `ACT_PSC_RST;
      arr_q <= `ACT_ARR_RST;
      rep_cnt_q <= `ACT_REP_ZERO;
      dir_dn_q <= 1'b0;
      run_q <= 1'b0;
      en_q <= 1'b0;
      trg_q <= 1'b0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      hall_q <= 3'h0;
      upd_q <= 1'b0;
      trg_evt_q <= 1'b0;
      moved_q <= 1'b0;
      adc_q <= 1'b0;
      clr_q <= 1'b0;
      brk_act_q <= 1'b0;
      brk_q <= 1'b0;
      brk_evt_q <= 1'b0;
    end else begin
      psc_cnt_q <= psc_cnt_d;
      cnt_q <= cnt_d;
      psc_q <= psc_d;
      arr_q <= arr_d;
      rep_cnt_q <= rep_cnt_d;
      dir_dn_q <= dir_dn_d;
      run_q <= run_d;
      en_q <= cnt_en_i;
      trg_q <= trg_i;
      a_q <= enc_a_i;
      b_q <= enc_b_i;
      hall_q <= hall_i;
      upd_q <= upd_d;
      trg_evt_q <= trg_evt_d;
      moved_q <= moved_d;
      adc_q <= adc_d;
      clr_q <= clr_d;
      brk_act_q <= brk_act_d;
      brk_q <= brk_i;
      brk_evt_q <= brk_evt_d;
    end
  end

  // no shared or static storage, so two instances never disturb each other
  genvar gi;
  generate
    for (gi = 0; gi < `ACT_NCH; gi = gi + 1) begin : g_ch
      act_channel u_ch (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .mode_i(ch_mode_i[gi]),
        .cmp_i(cmp_i[gi]),
        .upd_i(upd_q),
        .moved_i(moved_q),
        .cnt_i(cnt_q),
        .cap_in_i((gi == 0 && slv_mode_i == act_pkg::slv_hall) ? hall_chg : cap_i[gi]),
        .pol_i(pol_i[gi]),
        .dt_i(dt_i),
        .safe_i(brk_act_q || freeze),
        .idle_lvl_i(idle_lvl_i[gi]),
        .idle_n_lvl_i(idle_n_lvl_i[gi]),
        .clr_i(clr_q),
        .out_o(ch_out_o[gi]),
        .out_n_o(ch_out_n_o[gi]),
        .cap_val_o(cap_val_o[gi]),
        .evt_o(cc_evt_o[gi])
      );
    end
  endgenerate

  assign cnt_o = cnt_q;
  assign dir_dn_o = dir_dn_q;
  assign upd_evt_o = upd_q;
  assign trg_evt_o = trg_evt_q;
  assign brk_evt_o = brk_evt_q;
  assign trgo_o = upd_q;
  assign adc_trg_o = adc_q;
endmodule : act_timer

// [src/act_params.svh]
// constants of the advanced control timer
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH
`define ACT_CNT_W 16
`define ACT_NCH 4
`define ACT_REP_W 8
`define ACT_DT_W 8
`define ACT_CNT_ZERO 16'h0000
`define ACT_CNT_STEP 16'h0001
`define ACT_ARR_RST 16'hFFFF
`define ACT_PSC_RST 16'h0000
`define ACT_REP_ZERO 8'h00
`define ACT_REP_STEP 8'h01
`define ACT_DT_ZERO 8'h00
`define ACT_DT_STEP 8'h01
`endif

// [src/act_pkg.sv]
// types of the advanced control timer
package act_pkg;
  typedef enum logic [1:0] {cm_up, cm_down, cm_center} act_cnt_mode_type;
  typedef enum logic [2:0] {
    slv_off, slv_encoder, slv_hall, slv_extclk, slv_reset, slv_gated, slv_trigger
  } act_slv_mode_type;
  typedef enum logic [2:0] {chm_frozen, chm_capture, chm_toggle, chm_pwm1, chm_pwm2} act_ch_mode_type;
endpackage : act_pkg

// [src/act_channel.sv]
// one capture/compare channel with complementary dead-time output
`timescale 1ns/10ps
`include "act_params.svh"
module act_channel (
  input wire logic clk_i,
  input wire logic rstn_i,
  input act_pkg::act_ch_mode_type mode_i,
  input wire logic [`ACT_CNT_W-1:0] cmp_i,
  input wire logic upd_i,
  input wire logic moved_i,
  input wire logic [`ACT_CNT_W-1:0] cnt_i,
  input wire logic cap_in_i,
  input wire logic pol_i,
  input wire logic [`ACT_DT_W-1:0] dt_i,
  input wire logic safe_i,
  input wire logic idle_lvl_i,
  input wire logic idle_n_lvl_i,
  input wire logic clr_i,
  output logic out_o,
  output logic out_n_o,
  output logic [`ACT_CNT_W-1:0] cap_val_o,
  output logic evt_o
);
  logic [`ACT_CNT_W-1:0] cmp_q, cmp_d, cap_q, cap_d;
  logic [`ACT_DT_W-1:0] dt_q, dt_d;
  logic ref_q, ref_d, cap_prev_q, out_q, out_d, out_n_q, out_n_d, evt_q, evt_d;
  logic match, is_pwm;

  assign match = moved_i && (cnt_i == cmp_q);
  assign is_pwm = (mode_i == act_pkg::chm_pwm1) || (mode_i == act_pkg::chm_pwm2);

  always_comb begin
    cmp_d = upd_i ? cmp_i : cmp_q;
    ref_d = ref_q;
    cap_d = cap_q;
    evt_d = 1'b0;
    case (mode_i)
      act_pkg::chm_capture: begin
        if (cap_in_i && !cap_prev_q) begin
          cap_d = cnt_i;
          evt_d = 1'b1;
        end
      end
      act_pkg::chm_toggle: begin
        if (match) begin
          ref_d = ~ref_q;
        end
        evt_d = match;
      end
      act_pkg::chm_pwm1: begin
        ref_d = cnt_i < cmp_q;
        evt_d = match;
      end
      act_pkg::chm_pwm2: begin
        ref_d = !(cnt_i < cmp_q);
        evt_d = match;
      end
      default: begin
        evt_d = match;
      end
    endcase
    if (clr_i && is_pwm) begin
      ref_d = 1'b0;
    end
    // both legs stay off while the gap counts down, so a pair never conducts together
    if (ref_d != ref_q) begin
      dt_d = dt_i;
    end else if (dt_q != `ACT_DT_ZERO) begin
      dt_d = dt_q - `ACT_DT_STEP;
    end else begin
      dt_d = dt_q;
    end
    if (safe_i || mode_i == act_pkg::chm_capture) begin
      out_d = idle_lvl_i;
      out_n_d = idle_n_lvl_i;
      // re-arm the gap so leaving break or halt cannot switch a leg on at once
      dt_d = dt_i;
    end else begin
      out_d = (ref_q && dt_q == `ACT_DT_ZERO) ^ pol_i;
      out_n_d = (!ref_q && dt_q == `ACT_DT_ZERO) ^ pol_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp_q <= `ACT_CNT_ZERO;
      cap_q <= `ACT_CNT_ZERO;
      dt_q <= `ACT_DT_ZERO;
      ref_q <= 1'b0;
      cap_prev_q <= 1'b0;
      out_q <= 1'b0;
      out_n_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      cap_q <= cap_d;
      dt_q <= dt_d;
      ref_q <= ref_d;
      cap_prev_q <= cap_in_i;
      out_q <= out_d;
      out_n_q <= out_n_d;
      evt_q <= evt_d;
    end
  end

  assign out_o = out_q;
  assign out_n_o = out_n_q;
  assign cap_val_o = cap_q;
  assign evt_o = evt_q;
endmodule : act_channel

// [testbench/act_timer_checker.sv]
// port assertions for the advanced control timer
`timescale 1ns/10ps
module act_timer_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cnt_en_i,
  input act_pkg::act_cnt_mode_type cnt_mode_i,
  input act_pkg::act_slv_mode_type slv_mode_i,
  input wire logic sw_update_i,
  input wire logic brk_i,
  input wire logic brk_en_i,
  input wire logic dbg_halt_i,
  input wire logic dbg_freeze_i,
  input wire logic [15:0] adc_pos_i,
  input act_pkg::act_ch_mode_type ch_mode_i [4],
  input wire logic [15:0] cmp_i [4],
  input wire logic [3:0] pol_i,
  input wire logic [3:0] idle_lvl_i,
  input wire logic [3:0] idle_n_lvl_i,
  input wire logic [7:0] dt_i,
  input wire logic [3:0] ch_out_o,
  input wire logic [3:0] ch_out_n_o,
  input wire logic [3:0] cc_evt_o,
  input wire logic [15:0] cnt_o,
  input wire logic upd_evt_o,
  input wire logic brk_evt_o,
  input wire logic trgo_o,
  input wire logic adc_trg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_idle;
    ch_out_o == idle_lvl_i && ch_out_n_o == idle_n_lvl_i;
  endsequence
  sequence s_halted;
    (dbg_halt_i && dbg_freeze_i) [*4];
  endsequence
  a_trgo_mirrors_upd: assert property (trgo_o == upd_evt_o)
    else $error("trigger output differs from update");
  a_break_forces_idle: assert property (brk_en_i && $rose(brk_i) |-> ##[1:3] s_idle)
    else $error("break did not force idle levels");
  a_break_evt_pulse: assert property (brk_evt_o |=> !brk_evt_o)
    else $error("break event longer than one cycle");
  a_debug_freeze_idle: assert property (s_halted |-> s_idle ##0 $stable(cnt_o))
    else $error("debug halt did not freeze");
  // reinit by software is excluded: it reloads the count (zero, or arr_i when counting down) even while stopped
  a_stop_holds_cnt: assert property ((!cnt_en_i && !sw_update_i && slv_mode_i == act_pkg::slv_off) [*2] |=>
    $stable(cnt_o)) else $error("counter moved while disabled");
  a_up_update_zero: assert property (upd_evt_o && cnt_mode_i == act_pkg::cm_up &&
    $past(cnt_mode_i) == act_pkg::cm_up && slv_mode_i != act_pkg::slv_encoder |-> cnt_o == 16'h0000)
    else $error("up-count update away from zero");
  a_dead_time_gap: assert property ($rose(ch_out_o[0]) && dt_i == 8'h04 && !pol_i[0] |->
    !ch_out_n_o[0] && $past(ch_out_n_o[0], 4) == 1'b0) else $error("dead time too short");
  // the match flag and the new count share an edge, so the event follows one cycle later
  a_cmp_match_evt: assert property ($changed(cnt_o) && cnt_o == cmp_i[0] &&
    ch_mode_i[0] == act_pkg::chm_pwm1 |-> ##1 cc_evt_o[0]) else $error("compare match event missing");
  a_adc_at_pos: assert property (adc_trg_o |-> cnt_o == adc_pos_i || $past(cnt_o) == adc_pos_i)
    else $error("adc trigger away from position");
endmodule : act_timer_checker
bind act_timer act_timer_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .cnt_en_i(cnt_en_i),
  .cnt_mode_i(cnt_mode_i), .slv_mode_i(slv_mode_i), .sw_update_i(sw_update_i), .brk_i(brk_i),
  .brk_en_i(brk_en_i), .dbg_halt_i(dbg_halt_i), .dbg_freeze_i(dbg_freeze_i), .adc_pos_i(adc_pos_i),
  .ch_mode_i(ch_mode_i), .cmp_i(cmp_i), .pol_i(pol_i), .idle_lvl_i(idle_lvl_i), .idle_n_lvl_i(idle_n_lvl_i),
  .dt_i(dt_i), .ch_out_o(ch_out_o), .ch_out_n_o(ch_out_n_o), .cc_evt_o(cc_evt_o), .cnt_o(cnt_o),
  .upd_evt_o(upd_evt_o), .brk_evt_o(brk_evt_o), .trgo_o(trgo_o), .adc_trg_o(adc_trg_o));

// [testbench/act_enc_model.sv]
// quadrature encoder on the far side
`timescale 1ns/10ps
module act_enc_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic fwd_i,
  output logic a_o,
  output logic b_o
);
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end
  // gray steps only: one phase changes per step, as a real disc does
  always @(posedge clk_i) begin
    if (step_i && ((a_o == b_o) == fwd_i)) a_o <= !a_o;
    else if (step_i) b_o <= !b_o;
  end
endmodule : act_enc_model

// [testbench/testbench.sv]
// self-checking bench of the advanced control timer
`timescale 1ns/10ps
module testbench;
  logic clk_i, rstn_i = 0, cnt_en_i = 0, sw_update_i = 0, trg_i = 0, brk_i = 0, brk_en_i = 0;
  logic brk_rel_i = 0, dbg_halt_i = 0, dbg_freeze_i = 0, step = 0, fwd = 1, enc_a, enc_b;
  act_pkg::act_cnt_mode_type cnt_mode_i = act_pkg::cm_up;
  act_pkg::act_slv_mode_type slv_mode_i = act_pkg::slv_off;
  act_pkg::act_ch_mode_type ch_mode_i [4];
  logic [15:0] psc_i = 16'h0000, arr_i = 16'h0002, adc_pos_i = 16'h0001, cnt_o, v;
  logic [15:0] cmp_i [4], cap_val_o [4];
  logic [7:0] rep_i = 8'h00, dt_i = 8'h04;
  logic [3:0] idle_lvl_i = 4'h0, idle_n_lvl_i = 4'h0, ch_out_o, ch_out_n_o, cc_evt_o;
  logic [3:0] cap_i = 4'h0;
  logic dir_dn_o, upd_evt_o, trg_evt_o, brk_evt_o, trgo_o, adc_trg_o;
  logic [31:0] c;
  int mismatches = 0, samples_checked = 0;
  act_enc_model enc_u (.clk_i(clk_i), .step_i(step), .fwd_i(fwd), .a_o(enc_a), .b_o(enc_b));
  act_timer dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .cnt_en_i(cnt_en_i), .cnt_mode_i(cnt_mode_i),
    .slv_mode_i(slv_mode_i), .opm_i(1'b0), .psc_i(psc_i), .arr_i(arr_i), .rep_i(rep_i),
    .sw_update_i(sw_update_i), .trg_i(trg_i), .clr_en_i(1'b0), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .hall_i(3'h0), .brk_i(brk_i), .brk_en_i(brk_en_i), .brk_rel_i(brk_rel_i), .dbg_halt_i(dbg_halt_i),
    .dbg_freeze_i(dbg_freeze_i), .adc_pos_i(adc_pos_i), .ch_mode_i(ch_mode_i), .cmp_i(cmp_i),
    .cap_i(cap_i), .pol_i(4'h0), .idle_lvl_i(idle_lvl_i), .idle_n_lvl_i(idle_n_lvl_i), .dt_i(dt_i),
    .ch_out_o(ch_out_o), .ch_out_n_o(ch_out_n_o), .cap_val_o(cap_val_o), .cc_evt_o(cc_evt_o),
    .cnt_o(cnt_o), .dir_dn_o(dir_dn_o), .upd_evt_o(upd_evt_o), .trg_evt_o(trg_evt_o),
    .brk_evt_o(brk_evt_o), .trgo_o(trgo_o), .adc_trg_o(adc_trg_o));
  // 40 MHz stays under the 48 MHz ceiling of the timer clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic st(input int n);
    repeat (n) @(posedge clk_i);
  endtask : st
  // outputs are read just after the edge, so they show the cycle before it
  task automatic wu(output logic [31:0] k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (upd_evt_o !== 1'b1 && k < 200);
  endtask : wu
  task automatic cfg(input act_pkg::act_cnt_mode_type m, input logic [15:0] p, input logic [15:0] a,
      input logic [7:0] r);
    cnt_mode_i <= m;
    psc_i <= p;
    arr_i <= a;
    rep_i <= r;
    cnt_en_i <= 1'b1;
    sw_update_i <= 1'b1;
    @(posedge clk_i) sw_update_i <= 1'b0;
    wu(c);
  endtask : cfg
  task automatic t_periods;
    cfg(act_pkg::cm_up, 16'h0000, 16'h0002, 8'h00);
    wu(c);
    chk("up period", 3, c);
    chk("wrap count", 0, cnt_o);
    chk("trigger out", 1, trgo_o);
    cfg(act_pkg::cm_up, 16'h0001, 16'h0003, 8'h00);
    wu(c);
    chk("prescaled period", 8, c);
    arr_i <= 16'h0001;
    wu(c);
    chk("old reload kept", 8, c);
    wu(c);
    chk("new reload", 4, c);
    cfg(act_pkg::cm_up, 16'h0000, 16'h0003, 8'h02);
    wu(c);
    chk("repetition period", 12, c);
    cfg(act_pkg::cm_down, 16'h0000, 16'h0003, 8'h00);
    wu(c);
    chk("down period", 4, c);
    chk("down direction", 1, dir_dn_o);
    cfg(act_pkg::cm_center, 16'h0000, 16'h0003, 8'h00);
    // the first half after a restart starts at zero and runs one step long; time a settled half
    wu(c);
    wu(c);
    chk("center half period", 3, c);
  endtask : t_periods
  task automatic pw;
    logic [31:0] h, n, b, a;
    h = 0;
    n = 0;
    b = 0;
    a = 0;
    repeat (16) begin
      @(posedge clk_i);
      h = h + ch_out_o[0];
      n = n + ch_out_n_o[0];
      b = b + (ch_out_o[0] & ch_out_n_o[0]);
      a = a + adc_trg_o;
    end
    chk("main high cycles", 4, h);
    chk("comp high cycles", 4, n);
    chk("overlap cycles", 0, b);
    chk("adc triggers", 1, a);
  endtask : pw
  task automatic t_pwm_break;
    ch_mode_i[0] <= act_pkg::chm_pwm1;
    adc_pos_i <= 16'h0005;
    idle_lvl_i <= 4'hA;
    idle_n_lvl_i <= 4'h5;
    cfg(act_pkg::cm_up, 16'h0000, 16'h000F, 8'h00);
    wu(c);
    pw();
    brk_en_i <= 1'b1;
    brk_i <= 1'b1;
    st(2);
    chk("break event", 1, brk_evt_o);
    st(2);
    chk("break main", 4'hA, ch_out_o);
    chk("break comp", 4'h5, ch_out_n_o);
    brk_i <= 1'b0;
    st(4);
    chk("break latched", 4'h5, ch_out_n_o);
    brk_rel_i <= 1'b1;
    @(posedge clk_i) brk_rel_i <= 1'b0;
    st(24);
    pw();
    dbg_halt_i <= 1'b1;
    dbg_freeze_i <= 1'b1;
    st(5);
    v = cnt_o;
    st(5);
    chk("frozen count", v, cnt_o);
    chk("halted main", 4'hA, ch_out_o);
    dbg_halt_i <= 1'b0;
    dbg_freeze_i <= 1'b0;
  endtask : t_pwm_break
  task automatic mv(input logic f);
    fwd <= f;
    repeat (8) begin
      step <= 1'b1;
      @(posedge clk_i) step <= 1'b0;
      st(3);
    end
  endtask : mv
  task automatic t_sensors;
    slv_mode_i <= act_pkg::slv_encoder;
    cfg(act_pkg::cm_up, 16'h0000, 16'h0064, 8'h00);
    mv(1'b1);
    chk("encoder span", 16'h0008, cnt_o);
    mv(1'b0);
    chk("encoder return", 0, cnt_o);
    slv_mode_i <= act_pkg::slv_extclk;
    cfg(act_pkg::cm_up, 16'h0000, 16'h0064, 8'h00);
    repeat (5) begin
      trg_i <= 1'b1;
      st(2);
      trg_i <= 1'b0;
      st(2);
    end
    st(4);
    chk("external clock count", 16'h0005, cnt_o);
    slv_mode_i <= act_pkg::slv_off;
  endtask : t_sensors
  task automatic t_capture;
    ch_mode_i[1] <= act_pkg::chm_capture;
    cfg(act_pkg::cm_up, 16'h0000, 16'h0064, 8'h00);
    st(3);
    cap_i[1] <= 1'b1;
    st(2);
    chk("capture value", 16'h0004, cap_val_o[1]);
    chk("capture event", 1, cc_evt_o[1]);
    slv_mode_i <= act_pkg::slv_reset;
    trg_i <= 1'b1;
    st(2);
    chk("trigger restart", 0, cnt_o);
    chk("trigger event", 1, trg_evt_o);
    trg_i <= 1'b0;
    slv_mode_i <= act_pkg::slv_off;
    cnt_en_i <= 1'b0;
    st(3);
    v = cnt_o;
    st(3);
    chk("stopped count", v, cnt_o);
  endtask : t_capture
  initial begin
    foreach (ch_mode_i[i]) ch_mode_i[i] = act_pkg::chm_frozen;
    foreach (cmp_i[i]) cmp_i[i] = 16'h0008;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    st(2);
    t_periods();
    t_pwm_break();
    t_sensors();
    t_capture();
    give_verdict();
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule : testbench
